// ===== common/isp_pkg.sv
package isp_pkg;

  // Serial programming command codes
  localparam logic [7:0] CMD_TIMING   = 8'h3b;
  localparam logic [7:0] CMD_PAGE_ERS = 8'hb3;
  localparam logic [7:0] CMD_MASS_ERS = 8'hbf;
  localparam logic [7:0] CMD_RD_BYTE  = 8'h1d;
  localparam logic [7:0] CMD_RD_MULTI = 8'ha3;
  localparam logic [7:0] CMD_WR_BYTE  = 8'h71;
  localparam logic [7:0] CMD_WR_MULTI = 8'h8f;
  localparam logic [7:0] CMD_EXIT     = 8'hd3;

  // User-mode entry points
  localparam logic [7:0] ENT_PAGE_ERS = 8'h17;
  localparam logic [7:0] ENT_MASS_ERS = 8'h1a;
  localparam logic [7:0] ENT_RD_BYTE  = 8'h11;
  localparam logic [7:0] ENT_RD_BLOCK = 8'h26;
  localparam logic [7:0] ENT_WR_BYTE  = 8'h14;
  localparam logic [7:0] ENT_WR_BLOCK = 8'h23;
  localparam logic [7:0] ENT_EXIT     = 8'h62;
  localparam logic [7:0] ENT_ISP      = 8'h00;

  localparam logic [2:0]  ARGS_BAD     = 3'h7;
  localparam logic [5:0]  KEY_PATTERN  = 6'b100110;
  localparam logic [3:0]  KEY_CYCLES   = 4'h8;
  localparam logic [7:0]  MASS_CONFIRM = 8'h55;
  localparam logic [15:0] OPTION_ADDR  = 16'hffff;
  localparam logic [7:0]  BLANK_BYTE   = 8'hff;
  localparam logic [7:0]  WR_MULTI_MAX = 8'h10;
  localparam logic [15:0] RD_COUNT_MSK = 16'h7fff;
  localparam logic [7:0]  TIMING_RST   = 8'h00;

  typedef enum logic [1:0] {
    MOP_READ   = 2'h0,
    MOP_WRITE  = 2'h1,
    MOP_PERASE = 2'h2,
    MOP_MERASE = 2'h3
  } isp_mop_e;

  typedef struct packed {
    logic       valid;
    isp_mop_e   op;
    logic [15:0] addr;
    logic [7:0] wdata;
  } isp_mem_req_s;

  typedef enum logic [7:0] {
    ST_IDLE   = 8'h01,
    ST_ARGS   = 8'h02,
    ST_EXEC   = 8'h04,
    ST_NEXT   = 8'h08,
    ST_WAIT   = 8'h10,
    ST_TX     = 8'h20,
    ST_RAM    = 8'h40,
    ST_BWDATA = 8'h80
  } isp_state_e;

endpackage : isp_pkg

// ===== core/isp_link.sv
`timescale 1ns/1ps
module isp_link (
  input  logic       sys_clk_in,
  input  logic       rst_n_in,
  input  logic       sck_in,
  input  logic       mosi_in,
  input  logic       select_n_in,
  input  logic       tx_load_in,
  input  logic [7:0] tx_data_in,
  output logic       rx_valid_out,
  output logic [7:0] rx_data_out,
  output logic       miso_out
);
  import isp_pkg::*;

  logic [2:0] pins;
  logic [2:0] filt;
  logic [2:0] s0;
  logic [2:0] s1;
  logic [2:0] s2;
  logic [2:0] bit_cnt;
  logic [7:0] rx_sh;
  logic [7:0] tx_sh;
  logic       sck_rise;
  logic       sck_fall;

  assign pins = {select_n_in, mosi_in, sck_in};

  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_sync
      always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          s0[i]   <= 1'b1;
          s1[i]   <= 1'b1;
          s2[i]   <= 1'b1;
          filt[i] <= 1'b1;
        end else begin
          s0[i] <= pins[i];
          s1[i] <= s0[i];
          s2[i] <= s1[i];
          if (s1[i] == s2[i]) begin
            filt[i] <= s2[i];
          end
        end
      end
    end
  endgenerate

  // Edges count only once two later stages agree
  assign sck_rise = s1[0] & s2[0] & ~filt[0];
  assign sck_fall = ~s1[0] & ~s2[0] & filt[0];

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bit_cnt      <= 3'h0;
      rx_sh        <= 8'h00;
      rx_data_out  <= 8'h00;
      rx_valid_out <= 1'b0;
    end else begin
      rx_valid_out <= 1'b0;
      if (filt[2]) begin
        bit_cnt <= 3'h0;
      end else if (sck_rise) begin
        rx_sh   <= {rx_sh[6:0], filt[1]};
        bit_cnt <= bit_cnt + 3'h1;
        if (bit_cnt == 3'h7) begin
          rx_data_out  <= {rx_sh[6:0], filt[1]};
          rx_valid_out <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_sh <= BLANK_BYTE;
    end else if (tx_load_in) begin
      tx_sh <= tx_data_in;
    end else if (sck_fall && !filt[2]) begin
      tx_sh <= {tx_sh[6:0], 1'b1};
    end
  end

  assign miso_out = tx_sh[7];

endmodule : isp_link

// ===== core/isp_command_interpreter.sv
`timescale 1ns/1ps
// Function
// RULE_01 - Exit command completes by pulsing device reset toward flash execution.
// RULE_02 - After exit, flash start only when boot-select option bit is 1.
// RULE_03 - Host sends write-pulse timing command first after entering serial mode.
// RULE_04 - Code B3 with page address erases that page, no reply.
// RULE_05 - Code BF with confirmation byte erases whole flash, no reply.
// RULE_06 - Code 1D returns flash byte, or FF while security set.
// RULE_07 - Single-byte read of address FFFF returns option register regardless.
// RULE_08 - Code A3 returns count flash bytes, or FF bytes when secured.
// RULE_09 - Code 71 programs one data byte at given address, no reply.
// RULE_10 - Code 8F programs up to 16 following bytes consecutively.
// RULE_11 - Host keeps block writes inside one 64-byte flash boundary.
// RULE_12 - Unknown command codes are dropped; interpreter awaits next command.
// RULE_13 - User mass erase ends in serial programming mode, not return.
// RULE_14 - User routine chosen by jump-to-boot operand entry value.
// RULE_15 - User routines copy blocks RAM to flash and flash to RAM.
// RULE_16 - Correct key arms flag eight cycles; jump without flag goes flash.
// RULE_17 - Caller loads accumulator with 55 before user mass erase.
module isp_command_interpreter (
  input  logic                 sys_clk_in,
  input  logic                 rst_n_in,
  input  logic                 sck_in,
  input  logic                 mosi_in,
  input  logic                 select_n_in,
  output logic                 miso_out,
  input  logic                 isp_enter_in,
  input  logic                 security_in,
  input  logic                 boot_select_in,
  input  logic [7:0]           option_in,
  output isp_pkg::isp_mem_req_s flash_req_out,
  input  logic                 flash_ack_in,
  input  logic [7:0]           flash_rdata_in,
  output isp_pkg::isp_mem_req_s ram_req_out,
  input  logic                 ram_ack_in,
  input  logic [7:0]           ram_rdata_in,
  input  logic                 key_write_in,
  input  logic [7:0]           key_data_in,
  input  logic                 jump_to_boot_instruction_in,
  input  logic [7:0]           jump_to_boot_instruction_entry_in,
  input  logic [15:0]          user_addr_in,
  input  logic [7:0]           user_count_in,
  input  logic [7:0]           user_wdata_in,
  input  logic [7:0]           user_acc_in,
  input  logic [15:0]          user_ram_addr_in,
  output logic                 isp_mode_out,
  output logic [7:0]           write_timing_out,
  output logic [7:0]           user_rdata_out,
  output logic                 user_done_out,
  output logic                 jump_to_flash_out,
  output logic                 device_reset_out,
  output logic                 boot_from_flash_out
);
  import isp_pkg::*;

  isp_state_e  state;
  logic [7:0]  cmd;
  logic [31:0] args;
  logic [2:0]  argn;
  logic [15:0] addr;
  logic [15:0] count;
  logic [15:0] ram_addr;
  logic        user;
  logic        to_host;
  logic        tx_load;
  logic [7:0]  tx_data;
  logic        rx_valid;
  logic [7:0]  rx_data;
  logic [3:0]  key_cnt;
  logic        key_flag;

  function automatic logic [2:0] arg_len(input logic [7:0] c);
    case (c)
      CMD_TIMING, CMD_MASS_ERS:   arg_len = 3'h1;
      CMD_PAGE_ERS, CMD_RD_BYTE:  arg_len = 3'h2;
      CMD_WR_BYTE, CMD_WR_MULTI:  arg_len = 3'h3;
      CMD_RD_MULTI:               arg_len = 3'h4;
      CMD_EXIT:                   arg_len = 3'h0;
      default:                    arg_len = ARGS_BAD;
    endcase
  endfunction : arg_len

  isp_link u_link (
    .sys_clk_in   (sys_clk_in),
    .rst_n_in     (rst_n_in),
    .sck_in       (sck_in),
    .mosi_in      (mosi_in),
    .select_n_in  (select_n_in),
    .tx_load_in   (tx_load),
    .tx_data_in   (tx_data),
    .rx_valid_out (rx_valid),
    .rx_data_out  (rx_data),
    .miso_out     (miso_out)
  );

  // Key flag lives for a fixed number of cycles after a matching write
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      key_cnt <= 4'h0;
    end else if (key_write_in && key_data_in[7:2] == KEY_PATTERN) begin
      key_cnt <= KEY_CYCLES; // RULE_16
    end else if (key_cnt != 4'h0) begin
      key_cnt <= key_cnt - 4'h1;
    end
  end
  assign key_flag = (key_cnt != 4'h0);

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state               <= ST_IDLE;
      cmd                 <= 8'h00;
      args                <= 32'h0;
      argn                <= 3'h0;
      addr                <= 16'h0;
      count               <= 16'h0;
      ram_addr            <= 16'h0;
      user                <= 1'b0;
      to_host             <= 1'b0;
      tx_load             <= 1'b0;
      tx_data             <= BLANK_BYTE;
      flash_req_out       <= '0;
      ram_req_out         <= '0;
      isp_mode_out        <= 1'b0;
      write_timing_out    <= TIMING_RST;
      user_rdata_out      <= 8'h00;
      user_done_out       <= 1'b0;
      jump_to_flash_out   <= 1'b0;
      device_reset_out    <= 1'b0;
      boot_from_flash_out <= 1'b0;
    end else begin
      tx_load           <= 1'b0;
      user_done_out     <= 1'b0;
      jump_to_flash_out <= 1'b0;
      device_reset_out  <= 1'b0;
      if (isp_enter_in) begin
        isp_mode_out <= 1'b1;
      end
      case (state)
        ST_IDLE: begin
          if (jump_to_boot_instruction_in && !isp_mode_out) begin
            if (key_flag) begin
              user     <= 1'b1; // RULE_14
              cmd      <= jump_to_boot_instruction_entry_in;
              addr     <= user_addr_in;
              count    <= {8'h00, user_count_in};
              ram_addr <= user_ram_addr_in;
              to_host  <= 1'b0;
              state    <= ST_EXEC;
            end else begin
              jump_to_flash_out <= 1'b1; // RULE_16
            end
          end else if (isp_mode_out && rx_valid) begin
            user <= 1'b0;
            cmd  <= rx_data;
            argn <= arg_len(rx_data);
            if (arg_len(rx_data) == ARGS_BAD) begin
              state <= ST_IDLE; // RULE_12
            end else if (arg_len(rx_data) == 3'h0) begin
              state <= ST_EXEC;
            end else begin
              state <= ST_ARGS;
            end
          end
        end
        ST_ARGS: begin
          if (rx_valid) begin
            args <= {args[23:0], rx_data};
            argn <= argn - 3'h1;
            if (argn == 3'h1) begin
              state <= ST_EXEC;
            end
          end
        end
        ST_EXEC: begin
          state <= ST_IDLE;
          case (cmd)
            CMD_TIMING: write_timing_out <= args[7:0];
            CMD_PAGE_ERS: begin
              flash_req_out <= '{1'b1, MOP_PERASE, args[15:0], 8'h00}; // RULE_04
              state         <= ST_WAIT;
            end
            ENT_PAGE_ERS: begin
              flash_req_out <= '{1'b1, MOP_PERASE, addr, 8'h00};
              state         <= ST_WAIT;
            end
            CMD_MASS_ERS: begin
              if (args[7:0] == MASS_CONFIRM) begin
                flash_req_out <= '{1'b1, MOP_MERASE, 16'h0, 8'h00}; // RULE_05
                state         <= ST_WAIT;
              end
            end
            ENT_MASS_ERS: begin
              if (user_acc_in == MASS_CONFIRM) begin
                flash_req_out <= '{1'b1, MOP_MERASE, 16'h0, 8'h00}; // RULE_17
                state         <= ST_WAIT;
              end else begin
                user_done_out <= 1'b1;
              end
            end
            CMD_RD_BYTE: begin
              addr    <= args[15:0];
              count   <= 16'h1;
              to_host <= 1'b1;
              state   <= ST_NEXT;
            end
            CMD_RD_MULTI: begin
              addr    <= args[31:16];
              count   <= args[15:0] & RD_COUNT_MSK; // RULE_08
              to_host <= 1'b1;
              state   <= ST_NEXT;
            end
            ENT_RD_BYTE: begin
              count <= 16'h1;
              state <= ST_NEXT;
            end
            ENT_RD_BLOCK: state <= ST_NEXT; // RULE_15
            CMD_WR_BYTE: begin
              flash_req_out <= '{1'b1, MOP_WRITE, args[23:8], args[7:0]}; // RULE_09
              state         <= ST_WAIT;
            end
            ENT_WR_BYTE: begin
              flash_req_out <= '{1'b1, MOP_WRITE, addr, user_wdata_in};
              state         <= ST_WAIT;
            end
            CMD_WR_MULTI: begin
              addr  <= args[23:8];
              count <= {8'h00, args[7:0]};
              if (args[7:0] != 8'h00 && args[7:0] <= WR_MULTI_MAX) begin
                state <= ST_BWDATA; // RULE_10
              end
            end
            ENT_WR_BLOCK: begin
              if (count == 16'h0) begin
                user_done_out <= 1'b1;
              end else begin
                ram_req_out <= '{1'b1, MOP_READ, ram_addr, 8'h00}; // RULE_15
                state       <= ST_RAM;
              end
            end
            CMD_EXIT, ENT_EXIT: begin
              device_reset_out    <= 1'b1; // RULE_01
              boot_from_flash_out <= boot_select_in; // RULE_02
              isp_mode_out        <= 1'b0;
            end
            ENT_ISP: begin
              isp_mode_out  <= 1'b1;
              user_done_out <= 1'b1;
            end
            default: user_done_out <= user;
          endcase
        end
        ST_NEXT: begin
          if (count == 16'h0) begin
            user_done_out <= user;
            state         <= ST_IDLE;
          end else if (to_host && cmd == CMD_RD_BYTE && addr == OPTION_ADDR) begin
            tx_data <= option_in; // RULE_07
            tx_load <= 1'b1;
            state   <= ST_TX;
          end else if (to_host && security_in) begin
            tx_data <= BLANK_BYTE; // RULE_06
            tx_load <= 1'b1;
            state   <= ST_TX;
          end else begin
            flash_req_out <= '{1'b1, MOP_READ, addr, 8'h00};
            state         <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (flash_ack_in) begin
            flash_req_out.valid <= 1'b0;
            state               <= ST_IDLE;
            if (flash_req_out.op == MOP_READ) begin
              if (to_host) begin
                tx_data <= flash_rdata_in; // RULE_06
                tx_load <= 1'b1;
                state   <= ST_TX;
              end else if (cmd == ENT_RD_BYTE) begin
                user_rdata_out <= flash_rdata_in;
                user_done_out  <= 1'b1;
              end else begin
                ram_req_out <= '{1'b1, MOP_WRITE, ram_addr, flash_rdata_in}; // RULE_15
                state       <= ST_RAM;
              end
            end else if (cmd == CMD_WR_MULTI || cmd == ENT_WR_BLOCK) begin
              addr     <= addr + 16'h1; // RULE_10
              ram_addr <= ram_addr + 16'h1;
              count    <= count - 16'h1;
              if (count == 16'h1) begin
                user_done_out <= user;
              end else if (cmd == CMD_WR_MULTI) begin
                state <= ST_BWDATA;
              end else begin
                ram_req_out <= '{1'b1, MOP_READ, ram_addr + 16'h1, 8'h00};
                state       <= ST_RAM;
              end
            end else if (cmd == ENT_MASS_ERS) begin
              isp_mode_out <= 1'b1; // RULE_13
            end else begin
              user_done_out <= user;
            end
          end
        end
        ST_TX: begin
          if (rx_valid) begin
            addr  <= addr + 16'h1; // RULE_08
            count <= count - 16'h1;
            state <= ST_NEXT;
          end
        end
        ST_RAM: begin
          if (ram_ack_in) begin
            ram_req_out.valid <= 1'b0;
            if (ram_req_out.op == MOP_READ) begin
              flash_req_out <= '{1'b1, MOP_WRITE, addr, ram_rdata_in};
              state         <= ST_WAIT;
            end else begin
              addr     <= addr + 16'h1;
              ram_addr <= ram_addr + 16'h1;
              count    <= count - 16'h1;
              state    <= ST_NEXT;
            end
          end
        end
        ST_BWDATA: begin
          if (rx_valid) begin
            flash_req_out <= '{1'b1, MOP_WRITE, addr, rx_data}; // RULE_10
            state         <= ST_WAIT;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  sequence s_exit_taken;
    state == ST_IDLE && isp_mode_out && !jump_to_boot_instruction_in && rx_valid && rx_data == CMD_EXIT;
  endsequence
  sequence s_exit_done;
    state == ST_EXEC ##1 device_reset_out;
  endsequence

  property p_exit_reset;
    @(posedge sys_clk_in) disable iff (!rst_n_in) s_exit_taken |=> s_exit_done;
  endproperty
  a_exit_reset: assert property (p_exit_reset) else $error("exit did not reset"); // RULE_01

  property p_boot_sel;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      device_reset_out |-> boot_from_flash_out == $past(boot_select_in);
  endproperty
  a_boot_sel: assert property (p_boot_sel) else $error("boot select not followed"); // RULE_02

  property p_page_erase;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      state == ST_EXEC && cmd == CMD_PAGE_ERS |=> flash_req_out.valid
        && flash_req_out.op == MOP_PERASE && flash_req_out.addr == $past(args[15:0]);
  endproperty
  a_page_erase: assert property (p_page_erase) else $error("page erase wrong"); // RULE_04

  property p_mass_guard;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      state == ST_EXEC && cmd == CMD_MASS_ERS && args[7:0] != MASS_CONFIRM
        |=> !flash_req_out.valid && state == ST_IDLE;
  endproperty
  a_mass_guard: assert property (p_mass_guard) else $error("unconfirmed erase"); // RULE_05

  property p_secure_read;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      state == ST_NEXT && to_host && security_in && count != 16'h0
        && !(cmd == CMD_RD_BYTE && addr == OPTION_ADDR) |=> tx_load && tx_data == BLANK_BYTE;
  endproperty
  a_secure_read: assert property (p_secure_read) else $error("secured data leaked"); // RULE_06

  property p_option_read;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      state == ST_NEXT && cmd == CMD_RD_BYTE && addr == OPTION_ADDR && count != 16'h0
        |=> tx_load && tx_data == $past(option_in);
  endproperty
  a_option_read: assert property (p_option_read) else $error("option read wrong"); // RULE_07

  property p_write_byte;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      state == ST_EXEC && cmd == CMD_WR_BYTE |=> flash_req_out.valid
        && flash_req_out.op == MOP_WRITE && flash_req_out.wdata == $past(args[7:0]);
  endproperty
  a_write_byte: assert property (p_write_byte) else $error("byte write wrong"); // RULE_09

  property p_invalid_cmd;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      state == ST_IDLE && isp_mode_out && !jump_to_boot_instruction_in && rx_valid && arg_len(rx_data) == ARGS_BAD
        |=> (state == ST_IDLE && !tx_load && !flash_req_out.valid) [*2];
  endproperty
  a_invalid_cmd: assert property (p_invalid_cmd) else $error("bad code acted on"); // RULE_12

  property p_user_mass_isp;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      state == ST_WAIT && cmd == ENT_MASS_ERS && flash_ack_in |=> isp_mode_out && !user_done_out;
  endproperty
  a_user_mass_isp: assert property (p_user_mass_isp) else $error("no isp after erase"); // RULE_13

  property p_key_window;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      key_write_in && key_data_in[7:2] == KEY_PATTERN ##1 !key_write_in [*8]
        |-> key_flag ##1 !key_flag;
  endproperty
  a_key_window: assert property (p_key_window) else $error("key outlived window"); // RULE_16

  property p_no_key_jump;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      state == ST_IDLE && jump_to_boot_instruction_in && !isp_mode_out && !key_flag |=> jump_to_flash_out;
  endproperty
  a_no_key_jump: assert property (p_no_key_jump) else $error("jump without key"); // RULE_16

endmodule : isp_command_interpreter

// ===== verif/isp_host_model.sv
`timescale 1ns/1ps
module isp_host_model (
  input  wire logic clk_in,
  input  wire logic miso_in,
  output logic      sck_out,
  output logic      mosi_out,
  output logic      select_n_out
);
  initial begin
    sck_out = 1'b0;
    mosi_out = 1'b1;
    select_n_out = 1'b1;
  end
  // One byte per frame, MSB first; clock stands low between frames
  task automatic xfer(input logic [7:0] d, output logic [7:0] q);
    select_n_out = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      mosi_out = d[i];
      repeat (4) @(negedge clk_in);
      sck_out = 1'b1;
      repeat (4) @(negedge clk_in);
      q[i] = miso_in;
      sck_out = 1'b0;
    end
    mosi_out = ~mosi_out;
    select_n_out = 1'b1;
    // Gap covers flash latency before the next byte
    repeat (20) @(negedge clk_in);
  endtask : xfer
endmodule : isp_host_model

// ===== verif/test_isp_command_interpreter.sv
`timescale 1ns/1ps
module test_isp_command_interpreter;
  import isp_pkg::*;
  logic         clk = 1'b0, rst_n = 1'b0, sck, mosi, sel_n, miso;
  logic         enter = 1'b0, sec = 1'b0, boot = 1'b1, fack = 1'b0, rack = 1'b0;
  logic         kw = 1'b0, jb = 1'b0, imode, udone, jflash, dreset, bflash;
  logic [7:0]   opt = 8'hc6, frd = 8'h00, kd = 8'h00, je = 8'h00, uacc = 8'h00;
  logic [7:0]   timing, urd, lwd, r;
  logic [7:0]   ucnt = 8'h00;
  logic [15:0]  uaddr = 16'h0000, laddr;
  logic [1:0]   lop;
  isp_mem_req_s freq, rreq, rlog;
  int           nreq = 0, n_rst = 0, n_done = 0, n_jf = 0, error_cnt = 0, total_checks = 0;

  isp_command_interpreter i_dut (
    .sys_clk_in(clk), .rst_n_in(rst_n), .sck_in(sck), .mosi_in(mosi), .select_n_in(sel_n),
    .miso_out(miso), .isp_enter_in(enter), .security_in(sec), .boot_select_in(boot),
    .option_in(opt), .flash_req_out(freq), .flash_ack_in(fack), .flash_rdata_in(frd),
    .ram_req_out(rreq), .ram_ack_in(rack), .ram_rdata_in(8'h3c), .key_write_in(kw),
    .key_data_in(kd), .jump_to_boot_instruction_in(jb), .jump_to_boot_instruction_entry_in(je), .user_addr_in(uaddr),
    .user_count_in(ucnt), .user_wdata_in(8'h00), .user_acc_in(uacc),
    .user_ram_addr_in(16'h0000), .isp_mode_out(imode), .write_timing_out(timing),
    .user_rdata_out(urd), .user_done_out(udone), .jump_to_flash_out(jflash),
    .device_reset_out(dreset), .boot_from_flash_out(bflash));
  isp_host_model i_host (.clk_in(clk), .miso_in(miso), .sck_out(sck), .mosi_out(mosi),
    .select_n_out(sel_n));

  always #50 clk = ~clk;
  function automatic logic [7:0] fdat(input logic [15:0] a);
    return a[7:0] ^ 8'h5a;
  endfunction : fdat
  // Flash and RAM answer one cycle after a request and log it
  always @(negedge clk) begin
    fack <= 1'b0;
    rack <= 1'b0;
    if (freq.valid && !fack) begin
      fack <= 1'b1;
      frd <= fdat(freq.addr);
      lop <= freq.op;
      laddr <= freq.addr;
      lwd <= freq.wdata;
      nreq <= nreq + 1;
    end
    if (rreq.valid && !rack) begin
      rack <= 1'b1;
      rlog <= rreq;
    end
  end
  always @(posedge clk) begin
    n_rst <= n_rst + dreset;
    n_done <= n_done + udone;
    n_jf <= n_jf + jflash;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic results;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  task automatic send(input logic [7:0] d);
    i_host.xfer(d, r);
  endtask : send
  task automatic enter_isp;
    @(negedge clk);
    enter = 1'b1;
    @(negedge clk);
    enter = 1'b0;
  endtask : enter_isp
  task automatic t_read(input logic [15:0] a, input logic s, input logic [7:0] exp);
    sec = s;
    send(CMD_RD_BYTE);
    send(a[15:8]);
    send(a[7:0]);
    send(8'hff);
    chk(r, exp);
  endtask : t_read
  task automatic t_block_read;
    sec = 1'b0;
    send(CMD_RD_MULTI);
    send(8'h00);
    send(8'h10);
    send(8'h00);
    send(8'h02);
    send(8'hff);
    chk(r, fdat(16'h0010));
    send(8'hff);
    chk(r, fdat(16'h0011));
  endtask : t_block_read
  task automatic t_flash_ops;
    int n0;
    send(CMD_WR_BYTE);
    send(8'h12);
    send(8'h34);
    send(8'ha5);
    chk({lop, laddr[13:0]}, {MOP_WRITE, 14'h1234});
    chk(lwd, 8'ha5);
    n0 = nreq;
    send(CMD_WR_MULTI);
    send(8'h00);
    send(8'h40);
    send(8'h02);
    send(8'hc1);
    send(8'hc2);
    chk(nreq - n0, 2);
    chk({lwd, laddr[7:0]}, 16'hc241);
    send(CMD_PAGE_ERS);
    send(8'h02);
    send(8'h00);
    chk({lop, laddr[13:0]}, {MOP_PERASE, 14'h0200});
    send(CMD_MASS_ERS);
    send(MASS_CONFIRM);
    chk(lop, MOP_MERASE);
    n0 = nreq;
    send(8'h55);
    send(CMD_TIMING);
    send(8'h4b);
    chk(timing, 8'h4b);
    chk(nreq - n0, 0);
  endtask : t_flash_ops
  task automatic t_exit(input logic b);
    int n0;
    n0 = n_rst;
    boot = b;
    enter_isp();
    send(CMD_EXIT);
    chk(n_rst - n0, 1);
    chk(bflash, b);
    chk(imode, 1'b0);
  endtask : t_exit
  task automatic t_jump(input logic key, input logic [7:0] ent);
    @(negedge clk);
    kw = key;
    kd = 8'h9b;
    @(negedge clk);
    kw = 1'b0;
    jb = 1'b1;
    je = ent;
    @(negedge clk);
    jb = 1'b0;
    repeat (12) @(negedge clk);
  endtask : t_jump
  // Copies between working memory and flash through the user entry points
  task automatic t_user_copy;
    int n0, d0;
    n0 = nreq;
    d0 = n_done;
    ucnt = 8'h02;
    uaddr = 16'h0300;
    t_jump(1'b1, ENT_WR_BLOCK);
    chk(nreq - n0, 2);
    chk({lwd, laddr[7:0]}, 16'h3c01);
    ucnt = 8'h01;
    t_jump(1'b1, ENT_RD_BLOCK);
    chk({rlog.op, rlog.wdata}, {MOP_WRITE, fdat(16'h0300)});
    chk(n_done - d0, 2);
  endtask : t_user_copy
  task automatic t_user;
    int d0, j0;
    d0 = n_done;
    j0 = n_jf;
    uaddr = 16'h0123;
    t_jump(1'b1, ENT_RD_BYTE);
    chk(n_done - d0, 1);
    chk(urd, fdat(16'h0123));
    t_jump(1'b0, ENT_RD_BYTE);
    chk(n_jf - j0, 1);
    chk(n_done - d0, 1);
    uacc = MASS_CONFIRM;
    t_jump(1'b1, ENT_MASS_ERS);
    chk(lop, MOP_MERASE);
    chk(imode, 1'b1);
  endtask : t_user

  initial begin
    #2000000;
    error_cnt++;
    results();
  end
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
    enter_isp();
    send(CMD_TIMING);
    send(8'h37);
    chk(timing, 8'h37);
    t_flash_ops();
    t_read(16'h0234, 1'b0, fdat(16'h0234));
    t_read(16'h0234, 1'b1, BLANK_BYTE);
    t_read(OPTION_ADDR, 1'b1, opt);
    t_block_read();
    t_exit(1'b1);
    t_user_copy();
    t_user();
    t_exit(1'b0);
    results();
  end
endmodule : test_isp_command_interpreter
